// >>> src/wrcs_consts.svh
// Constants for the waveform RAM command sequencer: offsets, fields, codes.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`ifndef WRCS_CONSTS_SVH
`define WRCS_CONSTS_SVH

// Register byte offsets
`define WRCS_OFF_CTRL 8'h00
`define WRCS_OFF_WAVE_IN 8'h04
`define WRCS_OFF_STATUS 8'h08
`define WRCS_OFF_RAM_ADDR 8'h0C
`define WRCS_OFF_RAM_DATA 8'h10

// Control register fields
`define WRCS_CTRL_MODE_LO 0
`define WRCS_CTRL_OE_BIT 2
`define WRCS_CTRL_SENSE_BIT 3

// Playback source select codes
`define WRCS_MODE_RAM_PLAY 2'h2
`define WRCS_MODE_BLOCK_SEQ 2'h3

// Command codes
`define WRCS_CMD_BLOCK_SEQ 16'h0012
`define WRCS_CMD_REPLAY 16'h0013

// Block index limit and RAM size
`define WRCS_BLOCK_MAX 4'hE
`define WRCS_RAM_DEPTH 1024
`define WRCS_RAM_AW 10

// Reset values
`define WRCS_CTRL_RESET 4'h0
`define WRCS_ADDR_RESET 10'h000

`endif

// >>> src/wrcs_pkg.sv
// Types shared by the waveform RAM command sequencer files.
// Assumes wrcs_consts.svh is compiled alongside.
`default_nettype none
package wrcs_pkg;

  // Block sequence parameter word
  typedef struct packed {
    logic [3:0] last_blk;
    logic [3:0] first_blk;
    logic [3:0] unused;
    logic halt;
    logic advance_wave_flag;
    logic advance_slice_flag;
    logic loop_enable;
  } wrcs_seq_word_t;

  // Replay word 1
  typedef struct packed {
    logic loop_enable;
    logic [4:0] first_lo;
    logic [9:0] last_loc;
  } wrcs_rep_w1_t;

  // Replay word 2
  typedef struct packed {
    logic zero;
    logic [4:0] first_hi;
    logic [9:0] return_loc;
  } wrcs_rep_w2_t;

  // Command decoder states
  typedef enum logic [3:0] {
    WRCS_CMD_IDLE = 4'b0001,
    WRCS_CMD_SEQ_P1 = 4'b0010,
    WRCS_CMD_REP_P1 = 4'b0100,
    WRCS_CMD_REP_P2 = 4'b1000
  } wrcs_cmd_state_t;

  // Playback states
  typedef enum logic [2:0] {
    WRCS_PB_STOP = 3'b001,
    WRCS_PB_SEQ = 3'b010,
    WRCS_PB_REP = 3'b100
  } wrcs_pb_state_t;

endpackage : wrcs_pkg
`default_nettype wire

// >>> src/wrcs_ram.sv
// Waveform sample memory: 1024 words of 16 bits, one write, one read port.
// Assumes a single clock; read data appears one edge after the address.
`timescale 1ns/1ps
`default_nettype none
`include "wrcs_consts.svh"

module wrcs_ram (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [9:0] waddr_i,
  input wire logic [15:0] wdata_i,
  // Read port
  input wire logic [9:0] raddr_i,
  output logic [15:0] rdata_o
);

  // Storage, no reset so it maps onto block RAM
  logic [15:0] mem [0:`WRCS_RAM_DEPTH-1];

  // ==========================================================
  // Synchronous write and read
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : wrcs_ram
`default_nettype wire

// >>> src/wrcs_top.sv
// Waveform RAM command sequencer: AHB-Lite registers, command decoder and
// block sequence / sample replay playback from the waveform RAM.
// Assumes one 125 MHz clock, the synthesizer and output driver on this clock,
// and an asynchronous sense event pin.
//
// Summary of operation
// - Source select 0x3 plays first..last block sequence
// - Sequence command marks ready; starts if drive on
// - Sense event starts prepared waveform when enabled
// - Bits 15:12 last, 11:8 first, max 0xE
// - Bits 3:0 halt, advance wave/slice, loop
// - Word1 bit15 loop: wrap to return location, else end
// - Word 1 bits 9:0 last replay location
// - Word 2 bits 9:0 return; ignored unless looping
// - New non-loop command ends loop after last location
// - Sample amplitude is RAM word bits 11:0
// - Replay command marks ready unless a replay is playing; starts if drive on
// - RAM holds 1024 locations, 0 to 1023
// - Advance slice flag moves to next slice
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wrcs_consts.svh"

module wrcs_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Sense event pin
  input wire logic sense_event_i,
  // Synthesizer handshake
  input wire logic block_done_i,
  input wire logic slice_done_i,
  output logic seq_active_o,
  output logic [3:0] block_idx_o,
  output logic [3:0] seq_flags_o,
  output logic slice_next_o,
  // Sample stream
  input wire logic sample_take_i,
  output logic sample_avail_o,
  output logic [11:0] sample_o
);

  // Bus and control state
  logic wr_pend_q; // Write data phase pending
  logic [7:0] wr_addr_q; // Address of pending write
  logic [3:0] ctrl_q; // Mode, drive enable, sense enable
  logic [15:0] wave_last_q; // Last word written to the waveform input
  logic [9:0] ram_addr_q; // Bus write pointer into RAM
  logic [2:0] sense_sync_q; // Two stage sync plus edge history
  logic sense_pulse; // One cycle sense event
  logic wave_wr; // Write to waveform input this cycle
  logic ram_wr; // Write to RAM data this cycle
  logic [15:0] ram_rdata; // RAM read data
  // Command decoder state
  wrcs_pkg::wrcs_cmd_state_t cmd_q;
  wrcs_pkg::wrcs_rep_w1_t rep_w1_q; // Held replay word 1
  logic seq_done; // Valid sequence parameter accepted
  logic rep_done; // Replay word 2 accepted
  // Playback settings and state
  wrcs_pkg::wrcs_pb_state_t pb_q;
  wrcs_pkg::wrcs_seq_word_t seq_q; // Programmed block sequence
  logic [9:0] last_loc_q; // Last replay location
  logic [9:0] ret_loc_q; // Loop return location
  logic rep_loop_q; // Replay loop enable
  logic [9:0] first_loc_q; // First replay location
  logic ready_q; // Waveform prepared, not yet started
  logic ready_seq_q; // Prepared waveform is a sequence
  logic start; // Begin playback this cycle
  logic [9:0] fetch_q; // RAM fetch location
  logic fetch_vld_q; // RAM data matches fetch location
  logic take; // Sample consumed this cycle

  // ==========================================================
  // Helpers
  // ==========================================================
  // Address decode used by the write path only; the read path decodes with a case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ==========================================================
  // AHB-Lite slave
  // ==========================================================
  // Zero wait states, always OKAY; only word transfers are meaningful
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // Capture write address phase; data arrives next cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready_i) begin
      wr_pend_q <= hsel_i && htrans_i[1] && hwrite_i;
      wr_addr_q <= haddr_i;
    end
  end

  assign wave_wr = wr_pend_q && hit(wr_addr_q, `WRCS_OFF_WAVE_IN);
  assign ram_wr = wr_pend_q && hit(wr_addr_q, `WRCS_OFF_RAM_DATA);

  // Read data registered in the address phase; unmapped reads return zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h00000000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      case (haddr_i)
        `WRCS_OFF_CTRL: hrdata_o <= {28'h0000000, ctrl_q};
        `WRCS_OFF_WAVE_IN: hrdata_o <= {16'h0000, wave_last_q};
        `WRCS_OFF_STATUS: hrdata_o <= {6'h00, fetch_q, 4'h0, block_idx_o,
                                       3'h0, cmd_q == wrcs_pkg::WRCS_CMD_IDLE,
                                       ready_q, pb_q};
        `WRCS_OFF_RAM_ADDR: hrdata_o <= {22'h000000, ram_addr_q};
        default: hrdata_o <= 32'h00000000;
      endcase
    end
  end

  // Control and RAM pointer registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= `WRCS_CTRL_RESET;
      wave_last_q <= 16'h0000;
      ram_addr_q <= `WRCS_ADDR_RESET;
    end else begin
      if (wr_pend_q && hit(wr_addr_q, `WRCS_OFF_CTRL)) begin
        ctrl_q <= hwdata_i[3:0];
      end
      if (wave_wr) begin
        wave_last_q <= hwdata_i[15:0];
      end
      // Pointer steps after each data word so a load can stream
      if (wr_pend_q && hit(wr_addr_q, `WRCS_OFF_RAM_ADDR)) begin
        ram_addr_q <= hwdata_i[9:0];
      end else if (ram_wr) begin
        ram_addr_q <= ram_addr_q + 10'h001;
      end
    end
  end

  // ==========================================================
  // Sense event synchroniser and edge detect
  // ==========================================================
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sense_sync_q <= 3'h0;
    end else begin
      sense_sync_q <= {sense_sync_q[1:0], sense_event_i};
    end
  end
  // Edge taken from the second and third stages only
  assign sense_pulse = sense_sync_q[1] && !sense_sync_q[2];

  // ==========================================================
  // Command decoder
  // ==========================================================
  assign seq_done = wave_wr && cmd_q == wrcs_pkg::WRCS_CMD_SEQ_P1 &&
                    hwdata_i[15:12] <= `WRCS_BLOCK_MAX &&
                    hwdata_i[11:8] <= `WRCS_BLOCK_MAX;
  assign rep_done = wave_wr && cmd_q == wrcs_pkg::WRCS_CMD_REP_P2;

  // Out-of-range indices drop the command rather than play garbage blocks
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_q <= wrcs_pkg::WRCS_CMD_IDLE;
      rep_w1_q <= '0;
    end else if (wave_wr) begin
      case (cmd_q)
        wrcs_pkg::WRCS_CMD_IDLE: begin
          if (hwdata_i[15:0] == `WRCS_CMD_BLOCK_SEQ) begin
            cmd_q <= wrcs_pkg::WRCS_CMD_SEQ_P1;
          end else if (hwdata_i[15:0] == `WRCS_CMD_REPLAY) begin
            cmd_q <= wrcs_pkg::WRCS_CMD_REP_P1;
          end
        end
        wrcs_pkg::WRCS_CMD_SEQ_P1: begin
          cmd_q <= wrcs_pkg::WRCS_CMD_IDLE;
        end
        wrcs_pkg::WRCS_CMD_REP_P1: begin
          rep_w1_q <= hwdata_i[15:0];
          cmd_q <= wrcs_pkg::WRCS_CMD_REP_P2;
        end
        default: begin
          cmd_q <= wrcs_pkg::WRCS_CMD_IDLE;
        end
      endcase
    end
  end

  // Latch programmed parameters
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_q <= '0;
      last_loc_q <= `WRCS_ADDR_RESET;
      ret_loc_q <= `WRCS_ADDR_RESET;
      first_loc_q <= `WRCS_ADDR_RESET;
      rep_loop_q <= 1'b0;
    end else begin
      if (seq_done) begin
        seq_q <= hwdata_i[15:0];
      end
      if (rep_done) begin
        rep_loop_q <= rep_w1_q.loop_enable;
        last_loc_q <= rep_w1_q.last_loc;
        ret_loc_q <= hwdata_i[9:0];
        first_loc_q <= {hwdata_i[14:10], rep_w1_q.first_lo};
      end
    end
  end

  // ==========================================================
  // Ready and start
  // ==========================================================
  // A replay command during replay reloads the loop and location settings without marking ready
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_q <= 1'b0;
      ready_seq_q <= 1'b0;
    end else if (seq_done) begin
      ready_q <= 1'b1;
      ready_seq_q <= 1'b1;
    end else if (rep_done && pb_q != wrcs_pkg::WRCS_PB_REP) begin
      ready_q <= 1'b1;
      ready_seq_q <= 1'b0;
    end else if (start) begin
      ready_q <= 1'b0;
    end
  end

  // Sense trigger only matters while drive is off; with drive on it starts anyway
  assign start = ready_q && (ctrl_q[`WRCS_CTRL_OE_BIT] ||
                 (ctrl_q[`WRCS_CTRL_SENSE_BIT] && sense_pulse)) &&
                 ctrl_q[1:0] == (ready_seq_q ? `WRCS_MODE_BLOCK_SEQ
                                             : `WRCS_MODE_RAM_PLAY);
  assign take = pb_q == wrcs_pkg::WRCS_PB_REP && sample_take_i && fetch_vld_q;

  // ==========================================================
  // Playback sequencing
  // ==========================================================
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pb_q <= wrcs_pkg::WRCS_PB_STOP;
      block_idx_o <= 4'h0;
      fetch_q <= `WRCS_ADDR_RESET;
    end else if (start && ready_seq_q) begin
      pb_q <= wrcs_pkg::WRCS_PB_SEQ;
      block_idx_o <= seq_q.first_blk;
    end else if (start) begin
      pb_q <= wrcs_pkg::WRCS_PB_REP;
      fetch_q <= first_loc_q;
    end else begin
      case (pb_q)
        wrcs_pkg::WRCS_PB_SEQ: begin
          if (block_done_i) begin
            if (seq_q.halt) begin
              pb_q <= wrcs_pkg::WRCS_PB_STOP;
            end else if (block_idx_o != seq_q.last_blk) begin
              block_idx_o <= block_idx_o + 4'h1;
            end else if (seq_q.loop_enable) begin
              block_idx_o <= seq_q.first_blk;
            end else begin
              pb_q <= wrcs_pkg::WRCS_PB_STOP;
            end
          end
        end
        wrcs_pkg::WRCS_PB_REP: begin
          if (take) begin
            if (fetch_q != last_loc_q) begin
              fetch_q <= fetch_q + 10'h001;
            end else if (rep_loop_q) begin
              fetch_q <= ret_loc_q;
            end else begin
              pb_q <= wrcs_pkg::WRCS_PB_STOP;
            end
          end
        end
        default: begin
          pb_q <= wrcs_pkg::WRCS_PB_STOP;
        end
      endcase
    end
  end

  // RAM output lags the fetch location by one edge
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fetch_vld_q <= 1'b0;
    end else begin
      fetch_vld_q <= !(start || take) && pb_q == wrcs_pkg::WRCS_PB_REP;
    end
  end

  // Registered outputs toward synthesizer and driver
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sample_o <= 12'h000;
      sample_avail_o <= 1'b0;
      seq_active_o <= 1'b0;
      seq_flags_o <= 4'h0;
      slice_next_o <= 1'b0;
    end else begin
      if (take) begin
        sample_o <= ram_rdata[11:0];
      end
      sample_avail_o <= !(start || take) && pb_q == wrcs_pkg::WRCS_PB_REP &&
                        fetch_vld_q;
      seq_active_o <= pb_q == wrcs_pkg::WRCS_PB_SEQ;
      seq_flags_o <= seq_q[3:0];
      slice_next_o <= pb_q == wrcs_pkg::WRCS_PB_SEQ && slice_done_i &&
                      seq_q.advance_slice_flag;
    end
  end

  // ==========================================================
  // Waveform RAM
  // ==========================================================
  wrcs_ram u_ram (
    .clk_i(clk_i),
    .we_i(ram_wr),
    .waddr_i(ram_addr_q),
    .wdata_i(hwdata_i[15:0]),
    .raddr_i(fetch_q),
    .rdata_o(ram_rdata)
  );

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_SEQ_READY: assert property (seq_done |=> ready_q && ready_seq_q)
    else $error("sequence command did not mark ready");
  AST_SEQ_START: assert property (
    seq_done && ctrl_q == 4'h7 && $stable(ctrl_q) |-> ##2 pb_q == wrcs_pkg::WRCS_PB_SEQ)
    else $error("sequence did not start with drive on");
  AST_REP_START: assert property (
    rep_done && ctrl_q == 4'h6 && $stable(ctrl_q) && pb_q == wrcs_pkg::WRCS_PB_STOP
    |-> ##2 pb_q == wrcs_pkg::WRCS_PB_REP && fetch_q == first_loc_q)
    else $error("replay did not start at first location");
  AST_SENSE: assert property (
    ready_q && ctrl_q[3] && !ctrl_q[2] && sense_pulse
    && ctrl_q[1:0] == (ready_seq_q ? 2'h3 : 2'h2) |=> !ready_q)
    else $error("sense event did not start playback");
  // An out-of-range parameter word must leave the programmed sequence untouched
  AST_RANGE: assert property (
    wave_wr && cmd_q == wrcs_pkg::WRCS_CMD_SEQ_P1
    && (hwdata_i[15:12] > 4'hE || hwdata_i[11:8] > 4'hE) |=> $stable(seq_q))
    else $error("block index out of range accepted");
  AST_STEP: assert property (
    take && fetch_q != last_loc_q && !start |=> fetch_q == $past(fetch_q) + 10'h001)
    else $error("fetch location did not step by one");
  AST_LOOP: assert property (
    take && fetch_q == last_loc_q && rep_loop_q && !start |=> fetch_q == $past(ret_loc_q))
    else $error("loop did not return");
  AST_END: assert property (
    take && fetch_q == last_loc_q && !rep_loop_q && !start
    |=> pb_q == wrcs_pkg::WRCS_PB_STOP)
    else $error("replay did not end after last location");
  AST_FIRST: assert property (
    rep_done |=> first_loc_q == {$past(hwdata_i[14:10]), $past(rep_w1_q.first_lo)})
    else $error("first location misassembled");
  AST_SAMPLE: assert property (take |=> sample_o == $past(ram_rdata[11:0]))
    else $error("sample amplitude wrong");
  AST_SLICE: assert property (
    pb_q == wrcs_pkg::WRCS_PB_SEQ && slice_done_i && seq_q.advance_slice_flag
    |=> slice_next_o)
    else $error("slice not advanced");

  COV_SEQ: cover property (seq_done ##[1:20] pb_q == wrcs_pkg::WRCS_PB_SEQ);
  COV_REP_LOOP: cover property (take && fetch_q == last_loc_q && rep_loop_q);
  COV_REP_END: cover property (take && fetch_q == last_loc_q && !rep_loop_q);
  COV_SENSE: cover property (ready_q && sense_pulse && !ctrl_q[2]);

endmodule : wrcs_top
`default_nettype wire

// >>> tb/wrcs_synth_model.sv
// Far-side model: synthesizer handshake and sample-consuming driver.
// Assumes the sequencer's clock and reset; en_i pauses every request.
`timescale 1ns/1ps
`default_nettype none

module wrcs_synth_model (
  // Clock, reset and pause
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic en_i,
  // From the sequencer
  input wire logic seq_active_i,
  input wire logic sample_avail_i,
  // To the sequencer
  output logic block_done_o,
  output logic slice_done_o,
  output logic sample_take_o
);
  logic [2:0] cnt_q; // Paces blocks and slices; also staggers takes

  // ==========
  // Block ends every six cycles of play, slice ends halfway through
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 3'h0;
      block_done_o <= 1'b0;
      slice_done_o <= 1'b0;
      sample_take_o <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 3'h5) ? 3'h0 : cnt_q + 3'h1;
      block_done_o <= en_i && seq_active_i && cnt_q == 3'h5;
      slice_done_o <= en_i && seq_active_i && cnt_q == 3'h2;
      // Only offered samples are taken; even counts stall to vary the pace
      sample_take_o <= en_i && sample_avail_i && !sample_take_o && cnt_q[0];
    end
  end
endmodule : wrcs_synth_model

`default_nettype wire

// >>> tb/waveform_ram_command_sequencer_tb_top.sv
// Self-checking bench for the sequencer: AHB-Lite master, RAM loads,
// replay and block sequences. Assumes the synth model on the far side.
`timescale 1ns/1ps
`default_nettype none
`include "wrcs_consts.svh"

module waveform_ram_command_sequencer_tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic en = 1'b0; // Far side allowed to act
  logic sense = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, sact, snext, savail, take, bdone, sdone;
  wire logic [3:0] bidx, sflags;
  wire logic [11:0] sample;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_take = 0;
  int n_blk = 0;
  logic [31:0] lfsr = 32'hA8E2425E;
  logic [31:0] rd;
  logic [15:0] mem [0:1023]; // Bench copy of what was loaded
  logic [9:0] exp_loc, last_b, ret_b, f;
  logic loop_b, seq_loop;
  logic chk_pend = 1'b0;
  logic sd_q = 1'b0;
  logic sf_q = 1'b0;
  logic [3:0] exp_blk, first_blk, last_blk;

  always #4 clk_i = ~clk_i;

  wrcs_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .sense_event_i(sense), .block_done_i(bdone), .slice_done_i(sdone),
    .seq_active_o(sact), .block_idx_o(bidx), .seq_flags_o(sflags),
    .slice_next_o(snext), .sample_take_i(take), .sample_avail_o(savail),
    .sample_o(sample));

  wrcs_synth_model u_model (.clk_i(clk_i), .reset_i(reset_i), .en_i(en),
    .seq_active_i(sact), .sample_avail_i(savail), .block_done_o(bdone),
    .slice_done_o(sdone), .sample_take_o(take));

  // ==========
  // Helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One single transfer; waits on hready, never on a cycle count
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Poll the playback state until it shows s, bounded
  task automatic wait_st(input logic [2:0] s);
    int i;
    ahb(1'b0, `WRCS_OFF_STATUS, 32'h0);
    for (i = 0; i < 400 && rd[2:0] !== s; i++) ahb(1'b0, `WRCS_OFF_STATUS, 32'h0);
  endtask : wait_st

  task automatic load(input logic [9:0] a);
    int k;
    ahb(1'b1, `WRCS_OFF_RAM_ADDR, {22'h0, a});
    for (k = 0; k < 6; k++) begin
      lfsr = nxt(lfsr);
      mem[10'(a + k)] = lfsr[15:0]; // Upper bits random too, must be dropped
      ahb(1'b1, `WRCS_OFF_RAM_DATA, {16'h0, lfsr[15:0]});
    end
  endtask : load

  task automatic rep(input logic lp, input logic [9:0] a, input logic [9:0] l,
                     input logic [9:0] r);
    loop_b = lp;
    last_b = l;
    ret_b = r;
    ahb(1'b1, `WRCS_OFF_WAVE_IN, {16'h0, `WRCS_CMD_REPLAY});
    ahb(1'b1, `WRCS_OFF_WAVE_IN, {16'h0, lp, a[4:0], l});
    ahb(1'b1, `WRCS_OFF_WAVE_IN, {16'h0, 1'b0, a[9:5], r});
  endtask : rep

  task automatic seq(input logic [3:0] a, input logic [3:0] l, input logic [3:0] fl);
    first_blk = a;
    last_blk = l;
    exp_blk = a;
    seq_loop = fl[0];
    n_blk = 0;
    ahb(1'b1, `WRCS_OFF_WAVE_IN, {16'h0, `WRCS_CMD_BLOCK_SEQ});
    ahb(1'b1, `WRCS_OFF_WAVE_IN, {16'h0, l, a, 4'h0, fl});
  endtask : seq

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // ==========
  // Monitor: each taken sample, slice advances and block order
  always @(posedge clk_i) begin
    if (chk_pend) begin
      check("sample", 32'(sample), 32'(mem[exp_loc][11:0]));
      exp_loc <= (loop_b && exp_loc == last_b) ? ret_b : exp_loc + 10'h1;
    end
    chk_pend <= take && savail;
    if (take && savail) n_take <= n_take + 1;
    sd_q <= sdone && sact;
    sf_q <= sflags[1];
    if (sd_q) check("slice_next", 32'(snext), 32'(sf_q));
    if (bdone && sact) begin
      check("block_idx", 32'(bidx), 32'(exp_blk));
      n_blk <= n_blk + 1;
      exp_blk <= (seq_loop && exp_blk == last_blk) ? first_blk : exp_blk + 4'h1;
    end
  end

  // Watchdog: whole plan needs well under 20k cycles
  initial begin
    repeat (50000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop();
  end

  // ==========
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    ahb(1'b0, `WRCS_OFF_CTRL, 32'h0);
    check("ctrl_reset", rd, 32'h0);
    ahb(1'b0, `WRCS_OFF_STATUS, 32'h0);
    check("status_reset", rd, 32'h11);
    ahb(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    lfsr = nxt(lfsr);
    f = {1'b0, lfsr[8:0]};
    load(f);
    ahb(1'b0, `WRCS_OFF_RAM_ADDR, 32'h0);
    check("ram_addr", rd, {22'h0, f + 10'h6});
    load(10'h3FA);
    ahb(1'b1, `WRCS_OFF_CTRL, 32'h6);
    en <= 1'b1;
    // Plain replay at a random place, then up to the top location
    exp_loc = f;
    n_take = 0;
    rep(1'b0, f, f + 10'h5, f + 10'h1);
    check("hresp", 32'(hresp), 32'h0);
    wait_st(3'b100);
    check("replay_start", 32'(rd[2:0]), 32'h4);
    wait_st(3'b001);
    check("replay_count", 32'(n_take), 32'h6);
    exp_loc = 10'h3FA;
    n_take = 0;
    rep(1'b0, 10'h3FA, 10'h3FF, 10'h000);
    wait_st(3'b100);
    wait_st(3'b001);
    check("top_count", 32'(n_take), 32'h6);
    check("avail_idle", 32'(savail), 32'h0);
    // Looping replay, then ended by a non-looping command
    exp_loc = f;
    n_take = 0;
    rep(1'b1, f, f + 10'h5, f + 10'h2);
    for (int i = 0; i < 2000 && n_take < 8; i++) @(posedge clk_i);
    en <= 1'b0;
    repeat (5) @(posedge clk_i);
    rep(1'b0, f, f + 10'h5, f + 10'h2);
    en <= 1'b1;
    wait_st(3'b001);
    check("loop_count", 32'(n_take), 32'hA);
    // Block sequences: dropped index, plain, looping, halt
    ahb(1'b1, `WRCS_OFF_CTRL, 32'h7);
    seq(4'h2, 4'hF, 4'h0);
    repeat (6) @(posedge clk_i);
    ahb(1'b0, `WRCS_OFF_STATUS, 32'h0);
    check("bad_index", 32'(rd[3:0]), 32'h1);
    seq(4'h2, 4'h4, 4'h4);
    wait_st(3'b010);
    check("seq_flags", 32'(sflags), 32'h4);
    wait_st(3'b001);
    check("seq_count", 32'(n_blk), 32'h3);
    seq(4'hD, 4'hE, 4'h3);
    for (int i = 0; i < 2000 && n_blk < 5; i++) @(posedge clk_i);
    check("loop_flags", 32'(sflags), 32'h3);
    en <= 1'b0;
    repeat (8) @(posedge clk_i);
    seq(4'hE, 4'hE, 4'h8);
    en <= 1'b1;
    wait_st(3'b001);
    check("halt_count", 32'(n_blk), 32'h1);
    // Sense-triggered start with drive off
    // Far side paused so the short block cannot end before the state is polled
    ahb(1'b1, `WRCS_OFF_CTRL, 32'hB);
    en <= 1'b0;
    seq(4'h1, 4'h1, 4'h0);
    repeat (10) @(posedge clk_i);
    ahb(1'b0, `WRCS_OFF_STATUS, 32'h0);
    check("ready_wait", 32'(rd[3:0]), 32'h9);
    sense <= 1'b1;
    repeat (6) @(posedge clk_i);
    sense <= 1'b0;
    wait_st(3'b010);
    check("sense_start", 32'(rd[2:0]), 32'h2);
    en <= 1'b1;
    wait_st(3'b001);
    check("sense_count", 32'(n_blk), 32'h1);
    report_and_stop();
  end
endmodule : waveform_ram_command_sequencer_tb_top

`default_nettype wire
